/* adc_regs.svh */
// timing and field constants for the converter daisy-chain readout
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

`define ADC_WORD_BITS   16
`define ADC_CLK_MHZ     125
`define ADC_T_CONV_NS   500
`define ADC_CONV_CYC    ((`ADC_T_CONV_NS * `ADC_CLK_MHZ + 999) / 1000)
`define ADC_SCK_HALF    5
`define ADC_WAIT_MARGIN 8
`define ADC_GAP_CYC     4
`define ADC_N_DEV       2
`define ADC_FIFO_DEPTH  32

`endif

/* adc_pkg.sv */
// state types for both ends of the converter chain link
`default_nettype none
package adc_pkg;

  typedef enum logic [1:0] {
    ADC_D_IDLE  = 2'b00,
    ADC_D_CONV  = 2'b01,
    ADC_D_BUSYW = 2'b10,
    ADC_D_SHIFT = 2'b11
  } adc_dev_state_t;

  typedef enum logic [2:0] {
    ADC_H_IDLE = 3'b000,
    ADC_H_PREP = 3'b001,
    ADC_H_WAIT = 3'b010,
    ADC_H_HI   = 3'b011,
    ADC_H_LO   = 3'b100,
    ADC_H_END  = 3'b101
  } adc_host_state_t;

endpackage
`default_nettype wire

/* adc_chain_if.sv */
// serial link between chain host and converter end
`timescale 1ns/1ns
`default_nettype none
interface adc_chain_if;
  logic convert_start;
  logic sck;
  logic sdi;
  logic sdo_o;
  logic sdo_oe;
  logic sdo;

  // pull-up on the data line while nobody drives it
  assign sdo = sdo_oe ? sdo_o : 1'b1;

  modport dev (
    input  convert_start,
    input  sck,
    input  sdi,
    output sdo_o,
    output sdo_oe
  );

  modport host (
    output convert_start,
    output sck,
    output sdi,
    input  sdo
  );
endinterface
`default_nettype wire

/* adc_dev_end.sv */
// converter end of the daisy-chain readout link
//
// Operation
// - low data-in at start edge selects chain
// - start and data-in low: drive output low
// - start edge, clock low: chain, no busy
// - start edge, clock high: chain with busy
// - host holds start high through readback
// - no busy: MSB out at conversion end
// - after conversion: acquire and power down
// - remaining bits shift out per falling edge
// - data-in enters shift register each fall except the first in busy mode
// - host gives sixteen clocks per device
// - busy: output high when chain finished
// - busy: sixteen per device plus one
// - output bit stable across both edges
// - host should capture on falling edge
// - readback time limits conversion rate
`include "adc_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module adc_dev_end #(
  parameter int unsigned DATA_W      = `ADC_WORD_BITS,
  parameter int unsigned CONV_CYC    = `ADC_CONV_CYC,
  parameter bit          CHAIN_FIRST = 1'b1
) (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  adc_chain_if.dev               link,
  input  wire logic [DATA_W-1:0] sample_in,
  output var  logic              conv_active,
  output var  logic              power_down,
  output var  logic              busy_mode,
  output var  logic              sample_taken
);

  // pin synchronisers: bit 0 first stage, bit 1 second, bit 2 history on start and clock only
  logic [2:0] cnv_q;
  logic [2:0] cnv_next;
  logic [2:0] sck_q;
  logic [2:0] sck_next;
  logic [1:0] sdi_q;
  logic [1:0] sdi_next;

  always_comb begin
    cnv_next = {cnv_q[1:0], link.convert_start};
    sck_next = {sck_q[1:0], link.sck};
    sdi_next = {sdi_q[0], link.sdi};
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnv_q <= 3'h0;
      sck_q <= 3'h0;
      sdi_q <= 2'h0;
    end else begin
      cnv_q <= cnv_next;
      sck_q <= sck_next;
      sdi_q <= sdi_next;
    end
  end

  logic s_cnv;
  logic s_sck;
  logic s_sdi;
  logic cnv_rise;
  logic cnv_fall;
  logic sck_fall;

  assign s_cnv    = cnv_q[1];
  assign s_sck    = sck_q[1];
  assign s_sdi    = sdi_q[1];
  assign cnv_rise = cnv_q[1] & ~cnv_q[2];
  assign cnv_fall = ~cnv_q[1] & cnv_q[2];
  assign sck_fall = ~sck_q[1] & sck_q[2];

  // conversion and shift state
  adc_pkg::adc_dev_state_t state_reg;
  adc_pkg::adc_dev_state_t state_next;
  logic [15:0]       cnt_reg;
  logic [15:0]       cnt_next;
  logic [DATA_W-2:0] sr_reg;
  logic [DATA_W-2:0] sr_next;
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] data_next;
  logic              out_reg;
  logic              out_next;
  logic              oe_reg;
  logic              oe_next;
  logic              busy_reg;
  logic              busy_next;
  logic              taken_reg;
  logic              taken_next;

  localparam logic [15:0] CONV_LAST = 16'(CONV_CYC - 1);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sr_next    = sr_reg;
    data_next  = data_reg;
    out_next   = out_reg;
    oe_next    = oe_reg;
    busy_next  = busy_reg;
    taken_next = 1'b0;
    case (state_reg)
      adc_pkg::ADC_D_IDLE: begin
        out_next = 1'b0;
        oe_next  = ~s_cnv & ~s_sdi;
        if (cnv_rise && !s_sdi) begin
          busy_next  = s_sck;
          cnt_next   = 16'h0000;
          oe_next    = 1'b1;
          state_next = adc_pkg::ADC_D_CONV;
        end
      end
      adc_pkg::ADC_D_CONV: begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == CONV_LAST) begin
          taken_next = 1'b1;
          data_next  = sample_in;
          if (busy_reg) begin
            out_next   = 1'b0;
            state_next = adc_pkg::ADC_D_BUSYW;
          end else begin
            out_next   = sample_in[DATA_W-1];
            sr_next    = sample_in[DATA_W-2:0];
            state_next = adc_pkg::ADC_D_SHIFT;
          end
        end
      end
      adc_pkg::ADC_D_BUSYW: begin
        // indicator rises once this and every upstream device is done
        out_next = CHAIN_FIRST | s_sdi;
        if (sck_fall) begin
          // upstream indicator bit is dropped here
          out_next   = data_reg[DATA_W-1];
          sr_next    = data_reg[DATA_W-2:0];
          state_next = adc_pkg::ADC_D_SHIFT;
        end
      end
      adc_pkg::ADC_D_SHIFT: begin
        // output only moves on a falling edge, so it holds over both
        if (sck_fall) begin
          out_next = sr_reg[DATA_W-2];
          sr_next  = {sr_reg[DATA_W-3:0], s_sdi};
        end
      end
      default: begin
        state_next = adc_pkg::ADC_D_IDLE;
      end
    endcase
    // frame ends when the host drops start
    if (cnv_fall && state_reg != adc_pkg::ADC_D_IDLE) begin
      state_next = adc_pkg::ADC_D_IDLE;
      out_next   = 1'b0;
      oe_next    = ~s_sdi;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= adc_pkg::ADC_D_IDLE;
      cnt_reg   <= 16'h0000;
      sr_reg    <= '0;
      data_reg  <= '0;
      out_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      busy_reg  <= 1'b0;
      taken_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sr_reg    <= sr_next;
      data_reg  <= data_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
      busy_reg  <= busy_next;
      taken_reg <= taken_next;
    end
  end

  // status flops
  logic stat_conv_reg;
  logic stat_conv_next;
  logic stat_pd_reg;
  logic stat_pd_next;

  always_comb begin
    stat_conv_next = (state_next == adc_pkg::ADC_D_CONV);
    stat_pd_next   = (state_next != adc_pkg::ADC_D_CONV);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stat_conv_reg <= 1'b0;
      stat_pd_reg   <= 1'b1;
    end else begin
      stat_conv_reg <= stat_conv_next;
      stat_pd_reg   <= stat_pd_next;
    end
  end

  assign link.sdo_o   = out_reg;
  assign link.sdo_oe  = oe_reg;
  assign conv_active  = stat_conv_reg;
  assign power_down   = stat_pd_reg;
  assign busy_mode    = busy_reg;
  assign sample_taken = taken_reg;

endmodule
`default_nettype wire

/* adc_host_end.sv */
// chain host: drives start and serial clock, stores words in a fifo
`include "adc_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module adc_fifo #(
  parameter int unsigned W = `ADC_WORD_BITS,
  parameter int unsigned D = `ADC_FIFO_DEPTH
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output var  logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output var  logic         out_valid,
  input  wire logic         out_ready,
  output var  logic [W-1:0] out_data
);
  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
  localparam int unsigned CW = $clog2(D + 1);
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  localparam logic [CW-1:0] FULL = CW'(D);

  logic [W-1:0]  mem_reg [D];
  logic [W-1:0]  mem_next [D];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic          push, pop;

  assign in_ready  = (cnt_reg != FULL);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rp_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    mem_next = mem_reg;
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wp_reg] = in_data;
      wp_next = (wp_reg == LAST) ? '0 : wp_reg + AW'(1);
    end
    if (pop) begin
      rp_next = (rp_reg == LAST) ? '0 : rp_reg + AW'(1);
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + CW'(1);
    end else if (pop && !push) begin
      cnt_next = cnt_reg - CW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < D; i++) begin
        mem_reg[i] <= '0;
      end
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule

module adc_host_end #(
  parameter int unsigned DATA_W   = `ADC_WORD_BITS,
  parameter int unsigned N_DEV    = `ADC_N_DEV,
  parameter int unsigned SCK_HALF = `ADC_SCK_HALF,
  parameter int unsigned WAIT_CYC = `ADC_CONV_CYC + `ADC_WAIT_MARGIN,
  parameter int unsigned DEPTH    = `ADC_FIFO_DEPTH
) (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  adc_chain_if.host              link,
  input  wire logic              start,
  input  wire logic              busy_sel,
  output var  logic              idle,
  output var  logic [DATA_W-1:0] m_data,
  output var  logic              m_valid,
  input  wire logic              m_ready
);
  localparam logic [15:0] HALF_LAST = 16'(SCK_HALF - 1);
  localparam logic [15:0] WAIT_LAST = 16'(WAIT_CYC - 1);
  localparam logic [15:0] NBITS     = 16'(N_DEV * DATA_W);
  localparam logic [4:0]  WLAST     = 5'(DATA_W - 1);

  logic [1:0] sdo_q;
  logic [1:0] sdo_next;

  always_comb begin
    sdo_next = {sdo_q[0], link.sdo};
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sdo_q <= 2'h0;
    end else begin
      sdo_q <= sdo_next;
    end
  end

  adc_pkg::adc_host_state_t st_reg, st_next;
  logic [15:0]       tmr_reg, tmr_next;
  logic [15:0]       bits_reg, bits_next;
  logic [4:0]        wcnt_reg, wcnt_next;
  logic [DATA_W-1:0] word_reg, word_next;
  logic              sck_reg, sck_next;
  logic              cnv_reg, cnv_next;
  logic              busy_reg, busy_next;
  logic              f_valid, f_ready;
  logic [DATA_W-1:0] f_data;
  logic              keep, complete;

  // first fall in busy mode carries the indicator, not data
  assign keep     = !(busy_reg && bits_reg == 16'h0000);
  assign complete = keep && (wcnt_reg == WLAST);
  assign f_data   = {word_reg[DATA_W-2:0], sdo_q[1]};

  always_comb begin
    st_next   = st_reg;
    tmr_next  = tmr_reg + 16'h0001;
    bits_next = bits_reg;
    wcnt_next = wcnt_reg;
    word_next = word_reg;
    sck_next  = sck_reg;
    cnv_next  = cnv_reg;
    busy_next = busy_reg;
    f_valid   = 1'b0;
    case (st_reg)
      adc_pkg::ADC_H_IDLE: begin
        tmr_next = 16'h0000;
        if (start) begin
          busy_next = busy_sel;
          sck_next  = busy_sel;
          bits_next = 16'h0000;
          wcnt_next = 5'h00;
          st_next   = adc_pkg::ADC_H_PREP;
        end
      end
      adc_pkg::ADC_H_PREP: begin
        if (tmr_reg == HALF_LAST) begin
          cnv_next = 1'b1;
          tmr_next = 16'h0000;
          st_next  = adc_pkg::ADC_H_WAIT;
        end
      end
      adc_pkg::ADC_H_WAIT: begin
        if (busy_reg ? sdo_q[1] : (tmr_reg == WAIT_LAST)) begin
          tmr_next = 16'h0000;
          sck_next = 1'b1;
          st_next  = adc_pkg::ADC_H_HI;
        end
      end
      adc_pkg::ADC_H_HI: begin
        if (tmr_reg >= HALF_LAST) begin
          tmr_next = tmr_reg;
          // capture just before driving the falling edge
          if (!complete || f_ready) begin
            f_valid   = complete;
            tmr_next  = 16'h0000;
            sck_next  = 1'b0;
            bits_next = bits_reg + 16'h0001;
            st_next   = adc_pkg::ADC_H_LO;
            if (keep) begin
              word_next = f_data;
              wcnt_next = complete ? 5'h00 : wcnt_reg + 5'h01;
            end
          end
        end
      end
      adc_pkg::ADC_H_LO: begin
        if (tmr_reg == HALF_LAST) begin
          tmr_next = 16'h0000;
          if (bits_reg == NBITS + {15'h0000, busy_reg}) begin
            cnv_next = 1'b0;
            st_next  = adc_pkg::ADC_H_END;
          end else begin
            sck_next = 1'b1;
            st_next  = adc_pkg::ADC_H_HI;
          end
        end
      end
      adc_pkg::ADC_H_END: begin
        // short recovery; whole frame sets the achievable rate
        if (tmr_reg == 16'(`ADC_GAP_CYC)) begin
          st_next = adc_pkg::ADC_H_IDLE;
        end
      end
      default: begin
        st_next = adc_pkg::ADC_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg   <= adc_pkg::ADC_H_IDLE;
      tmr_reg  <= 16'h0000;
      bits_reg <= 16'h0000;
      wcnt_reg <= 5'h00;
      word_reg <= '0;
      sck_reg  <= 1'b0;
      cnv_reg  <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      tmr_reg  <= tmr_next;
      bits_reg <= bits_next;
      wcnt_reg <= wcnt_next;
      word_reg <= word_next;
      sck_reg  <= sck_next;
      cnv_reg  <= cnv_next;
      busy_reg <= busy_next;
    end
  end

  adc_fifo #(
    .W (DATA_W),
    .D (DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .in_data   (f_data),
    .out_valid (m_valid),
    .out_ready (m_ready),
    .out_data  (m_data)
  );

  assign link.convert_start = cnv_reg;
  assign link.sck           = sck_reg;
  assign link.sdi           = 1'b0;
  assign idle               = (st_reg == adc_pkg::ADC_H_IDLE);

endmodule
`default_nettype wire

/* adc_chain_chk.sv */
// assertions on the host-side link of the converter chain
`include "adc_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module adc_chain_chk #(
  parameter int N_DEV    = `ADC_N_DEV,
  parameter int CONV_CYC = `ADC_CONV_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic convert_start,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic sdo
);
  localparam int         W_LO    = CONV_CYC;
  localparam int         W_HI    = CONV_CYC + 12;
  localparam logic [7:0] N_PLAIN = 8'(16 * N_DEV);
  localparam logic [7:0] N_BUSY  = 8'(16 * N_DEV + 1);
  logic       st_q_reg, sck_q_reg, busy_reg, rise, fall;
  logic       st_q_next, sck_q_next, busy_next;
  logic [7:0] n_fall_reg, n_fall_next, since_reg, since_next;

  always_comb begin
    rise = convert_start & ~st_q_reg;
    fall = sck_q_reg & ~sck;
    st_q_next = convert_start;
    sck_q_next = sck;
    busy_next = rise ? sck : busy_reg;
    n_fall_next = n_fall_reg;
    if (rise)
      n_fall_next = 8'h00;
    else if (convert_start && fall)
      n_fall_next = n_fall_reg + 8'h01;
    since_next = (since_reg == 8'hFF) ? since_reg : since_reg + 8'h01;
    if (fall)
      since_next = 8'h00;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q_reg   <= 1'b0;
      sck_q_reg  <= 1'b0;
      busy_reg   <= 1'b0;
      n_fall_reg <= 8'h00;
      since_reg  <= 8'hFF;
    end else begin
      st_q_reg   <= st_q_next;
      sck_q_reg  <= sck_q_next;
      busy_reg   <= busy_next;
      n_fall_reg <= n_fall_next;
      since_reg  <= since_next;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_idle_drive_low: assert property (
    (!convert_start)[*8] |=> sdo_oe && !sdo_o)
    else $error("data line not driven low while idle");
  a_sdi_low_start: assert property (
    $rose(convert_start) |-> !sdi ##1 !sdi)
    else $error("data-in not low at start");
  a_mode_sck_held: assert property (
    $rose(convert_start) |-> $stable(sck)[*4])
    else $error("clock moved while mode is picked");
  a_busy_flag_high: assert property (
    $rose(convert_start) && sck |-> ##[W_LO:W_HI] (sdo_oe && sdo_o))
    else $error("busy flag not driven high in time");
  a_busy_first_bit: assert property (
    fall && busy_reg && convert_start && n_fall_reg == 8'h00 |-> sdo)
    else $error("first clock not on busy flag");
  a_fall_count: assert property (
    $fell(convert_start) |-> n_fall_reg == (busy_reg ? N_BUSY : N_PLAIN))
    else $error("wrong clock count in frame");
  a_bit_settles: assert property (
    convert_start && $changed(sdo) && n_fall_reg != 8'h00
    |-> since_reg <= 8'h05)
    else $error("data changed away from the falling edge");
  a_one_bit_fall: assert property (
    convert_start && $changed(sdo) && n_fall_reg != 8'h00
    |=> ($stable(sdo) || !convert_start)[*6])
    else $error("data moved twice in one clock");

  c_busy_frame:  cover property ($rose(convert_start) && sck);
  c_plain_frame: cover property ($rose(convert_start) && !sck);
  c_full_busy:   cover property (n_fall_reg == N_BUSY);
endmodule
`default_nettype wire

/* adc_daisy_chain_readout_tb.sv */
// two-device chain with host, plus a lone device driven by hand
`include "adc_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module adc_daisy_chain_readout_tb;
  typedef struct packed {
    logic        b;
    logic [15:0] far;
    logic [15:0] near;
  } adc_tb_row_t;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        start = 1'b0;
  logic        busy_sel = 1'b0;
  logic        m_ready = 1'b0;
  logic        idle, m_valid, busy_near, f_conv, f_pd, f_taken;
  logic [15:0] m_data, w;
  logic [15:0] s_far = 16'h0000;
  logic [15:0] s_near = 16'h0000;
  logic [15:0] s_f = 16'hB38D;
  logic [16:0] sh;
  int          n_fail = 0;
  int          n_compared = 0;
  int          i;
  adc_tb_row_t rows [4] = '{'{1'b0, 16'hFFFF, 16'h0000},
    '{1'b1, 16'h8001, 16'h7FFE}, '{1'b0, 16'hA5C3, 16'h5A3C},
    '{1'b1, 16'h0001, 16'h8000}};

  adc_chain_if if_h ();
  adc_chain_if if_d0 ();
  adc_chain_if if_d1 ();
  adc_chain_if if_f ();
  assign if_d0.convert_start = if_h.convert_start;
  assign if_d0.sck = if_h.sck;
  assign if_d0.sdi = if_h.sdi;
  assign if_d1.convert_start = if_h.convert_start;
  assign if_d1.sck = if_h.sck;
  assign if_d1.sdi = if_d0.sdo;
  assign if_h.sdo_o = if_d1.sdo_o;
  assign if_h.sdo_oe = if_d1.sdo_oe;

  adc_host_end i_adc_host_end (.ref_clk, .nrst, .link(if_h), .start,
    .busy_sel, .idle, .m_data, .m_valid, .m_ready);
  adc_dev_end #(.CHAIN_FIRST(1'b1)) i_adc_dev_end_far (.ref_clk, .nrst,
    .link(if_d0), .sample_in(s_far), .conv_active(), .power_down(),
    .busy_mode(), .sample_taken());
  adc_dev_end #(.CHAIN_FIRST(1'b0)) i_adc_dev_end (.ref_clk, .nrst,
    .link(if_d1), .sample_in(s_near), .conv_active(), .power_down(),
    .busy_mode(busy_near), .sample_taken());
  adc_dev_end #(.CHAIN_FIRST(1'b1)) i_adc_dev_end_lone (.ref_clk, .nrst,
    .link(if_f), .sample_in(s_f), .conv_active(f_conv), .power_down(f_pd),
    .busy_mode(), .sample_taken(f_taken));
  adc_chain_chk i_adc_chain_chk (.ref_clk, .nrst,
    .convert_start(if_h.convert_start), .sck(if_h.sck), .sdi(if_h.sdi),
    .sdo_o(if_h.sdo_o), .sdo_oe(if_h.sdo_oe), .sdo(if_h.sdo));

  always #4 ref_clk = ~ref_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one host frame; lim bounds the wait for idle
  task automatic frame(input logic b, input int lim);
    int j;
    @(posedge ref_clk);
    start <= 1'b1;
    busy_sel <= b;
    @(posedge ref_clk);
    start <= 1'b0;
    cyc(2);
    for (j = 0; j < lim && idle !== 1'b1; j++) @(posedge ref_clk);
  endtask

  task automatic pop(output logic [15:0] d);
    int j;
    @(posedge ref_clk);
    m_ready <= 1'b1;
    for (j = 0; j < 400; j++) begin
      @(posedge ref_clk);
      if (m_valid === 1'b1) break;
    end
    d = (m_valid === 1'b1) ? m_data : 'x;
    m_ready <= 1'b0;
  endtask

  initial begin
    cyc(30000);
    n_fail++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    if_f.convert_start = 1'b0;
    if_f.sck = 1'b0;
    if_f.sdi = 1'b0;
    cyc(2);
    check(16'(idle), 16'h0001);
    check(16'(if_h.convert_start), 16'h0000);
    check(16'(f_pd), 16'h0001);
    check(16'(if_f.sdo_oe), 16'h0000);
    nrst <= 1'b1;
    cyc(10);
    check(16'(if_f.sdo_oe), 16'h0001);
    check(16'(if_f.sdo), 16'h0000);
    $display("reset done");
    for (i = 0; i < 4; i++) begin
      s_far <= rows[i].far;
      s_near <= rows[i].near;
      frame(rows[i].b, 900);
      check(16'(idle), 16'h0001);
      check(16'(busy_near), 16'(rows[i].b));
      pop(w);
      check(w, rows[i].near);
      pop(w);
      check(w, rows[i].far);
      $display("row %0d done", i);
    end
    for (i = 0; i < 17; i++) begin
      s_far <= 16'h1000 + 16'(i);
      s_near <= 16'h2000 + 16'(i);
      frame(1'b0, (i < 16) ? 900 : 700);
    end
    check(16'(idle), 16'h0000);
    check(16'(if_h.sck), 16'h0001);
    for (i = 0; i < 34; i++) begin
      pop(w);
      check(w, 16'(i / 2) + ((i % 2) ? 16'h1000 : 16'h2000));
    end
    cyc(20);
    check(16'(idle), 16'h0001);
    $display("fill done");
    // lone device: refused start with data-in high
    if_f.sdi <= 1'b1;
    cyc(4);
    if_f.convert_start <= 1'b1;
    cyc(80);
    check(16'(if_f.sdo), 16'h0001);
    check(16'(f_conv), 16'h0000);
    if_f.convert_start <= 1'b0;
    cyc(4);
    if_f.sdi <= 1'b0;
    cyc(10);
    if_f.convert_start <= 1'b1;
    cyc(6);
    check(16'(f_conv), 16'h0001);
    // conversion-done pulse: one cycle, near the conversion time
    for (i = 0; i < 200 && f_taken !== 1'b1; i++) cyc(1);
    check(16'(i > `ADC_CONV_CYC - 5), 16'h0001);
    check(16'(i < `ADC_CONV_CYC + 1), 16'h0001);
    cyc(1);
    check(16'(f_taken), 16'h0000);
    cyc(5);
    sh = {s_f, 1'b1};
    check(16'(if_f.sdo), 16'(sh[16]));
    check(16'(f_pd), 16'h0001);
    check(16'(f_conv), 16'h0000);
    if_f.sdi <= 1'b1;
    if_f.sck <= 1'b1;
    cyc(5);
    for (i = 0; i < 16; i++) begin
      if_f.sck <= 1'b0;
      sh = sh << 1;
      cyc(5);
      check(16'(if_f.sdo), 16'(sh[16]));
      if_f.sck <= 1'b1;
      cyc(5);
      check(16'(if_f.sdo), 16'(sh[16]));
    end
    if_f.convert_start <= 1'b0;
    cyc(8);
    $display("lone device done");
    // reset in mid-frame, then one clean frame
    s_far <= 16'h0F0F;
    s_near <= 16'hF0F0;
    frame(1'b0, 100);
    nrst <= 1'b0;
    cyc(2);
    check(16'(idle), 16'h0001);
    check(16'(if_h.convert_start), 16'h0000);
    check(16'(if_h.sck), 16'h0000);
    check(16'(m_valid), 16'h0000);
    nrst <= 1'b1;
    cyc(4);
    frame(1'b0, 900);
    check(16'(idle), 16'h0001);
    pop(w);
    check(w, 16'hF0F0);
    pop(w);
    check(w, 16'h0F0F);
    $display("mid-run reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
